// ===== verilog/touch_scan_pkg.sv
/*
 Shared constants and types of the capacitive touch scan controller:
 register offsets, field positions, reset values, sequencer states and carriers.
 Assumes a 32-bit APB register bus with byte addresses.
*/
`default_nettype none
package touch_scan_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CHAN = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_TIME = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PRESET = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_DEST = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h1c;
    // Control register bits
    localparam int CTRL_START = 0;
    localparam int CTRL_INIT = 1;
    localparam int CTRL_SHORT = 2;
    localparam int CTRL_SKIP1 = 3;
    localparam int CTRL_SKIP5 = 4;
    localparam int CTRL_TRIG = 8;
    // Channel register fields
    localparam int CHAN_SEL = 0;
    localparam int CHAN_SCAN = 8;
    localparam int CHAN_ORDER = 9;
    // Timing register fields
    localparam int TIME_CHG = 0;
    localparam int TIME_DIS1 = 8;
    localparam int TIME_DIS2 = 12;
    localparam int TIME_FLT = 16;
    localparam int TIME_SET = 20;
    localparam int TIME_POST = 24;
    // Status and count register fields
    localparam int STAT_SEQ = 0;
    localparam int STAT_OVF = 8;
    localparam int STAT_WEXIT = 9;
    localparam int COUNT_SEC = 16;
    // Reset values and limits
    localparam logic [4:0] PRESET_RST = 5'h07;
    localparam logic [15:0] PRIMARY_LIMIT = 16'h01ff;
    localparam logic [11:0] REC_BYTES = 12'h004;
    // Trigger select encodings
    localparam logic [1:0] TRIG_SW = 2'h0;
    localparam logic [1:0] TRIG_CMP = 2'h2;
    localparam logic [1:0] TRIG_EXT = 2'h3;

    // Sequencer states, numbered from zero in this order
    typedef enum logic [4:0] {
        S_IDLE, S_LOAD, S_CHARGE, S_INIT,
        S_C_DIS1, S_C_DIS2, S_C_FLOAT, S_C_DUMMY, S_C_SETTLE, S_C_MEAS, S_C_JUDGE, S_C_POST,
        S_F_DUMMY, S_F_DIS1, S_F_DIS2, S_F_FLOAT, S_F_DUMMY2, S_F_SETTLE, S_F_MEAS, S_F_JUDGE,
        S_F_CHECK, S_XFER_REQ, S_XFER_GAP, S_NEXT_CH, S_XFER_WAIT, S_DONE
    } seq_state_t;

    // Drive of the three system pins
    typedef struct packed {
        logic charge_o;
        logic charge_oe;
        logic bleed_o;
        logic bleed_oe;
        logic sense_o;
        logic sense_oe;
    } pins_t;

    // One 4-byte result record towards RAM
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic dma_sel;
    } xfer_t;
endpackage
`default_nettype wire

// ===== verilog/sync2.sv
/*
 Two-flop synchroniser for a group of asynchronous levels.
 Assumes each bit is an independent level; no bus coherency.
*/
`timescale 1ns/1ps
`default_nettype none
module sync2
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // sync2
`default_nettype wire

// ===== verilog/touch_scan_ctrl.sv
/*
 Capacitive touch scan controller: sequencer, counters, triggers, APB registers.
 Assumes pins, compare flag and trigger pin are asynchronous, while wait_mode,
 transfer acknowledge and completion acknowledge come from the same clock.
*/
// Contract
// - Sequencer walks numbered states upward per channel, then back to start.
// - Stay in coarse phase until sense judged low, then go fine.
// - Charge state: charge pin high, others floating, 1 to 128 cycles.
// - First discharge drives sense low 1 to 16 cycles, skippable.
// - Second discharge drives bleed and sense low 1 to 4 cycles.
// - Float all pins 1 to 8 cycles; optionally close bleed-charge short.
// - After dummy, settle 1 to 16 cycles floating, skippable.
// - Each phase has dummy, measure and judge states, pins floating.
// - After judging, 1 to 16 cycles floating; short opens again.
// - Final fine state: secondary nonzero repeats loop, zero goes to transfer.
// - Channel done raises transfer request, private DMA in wait mode.
// - Loop over selected channels, await transfer, interrupt, back to idle.
// - 16-bit up-only primary counter, 5-bit up/down secondary counter.
// - Secondary starts at preset, fine only, up on low, down on high, capped.
// - Result one at first low; result two when secondary hits zero.
// - Both results go as one 4-byte record from start address onward.
// - System controller while running, private DMA in wait mode.
// - Trigger select 00 software, 10 compare timer, 11 external pin.
// - Compare trigger starts on rising compare-match flag with start set.
// - External trigger starts on falling trigger pin with start set.
// - Single channel by field, or scan ascending or descending over channels 0 to the field, at most 17.
// - Stop after completion or start cleared; counters keep their values.
// - Primary overflow sets error flag and jumps to transfer request.
// - State returns to zero on completion acknowledge or initialize write only.
// - Leaving wait mode mid-measurement sets the wait-exit error flag.
`timescale 1ns/1ps
`default_nettype none
module touch_scan_ctrl
#(
    parameter int NUM_CH = 18
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [touch_scan_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sense_pin_i,
    output touch_scan_pkg::pins_t pins,
    output logic short_on,
    output logic [4:0] channel,
    input wire logic compare_match_flag,
    input wire logic external_trigger_pin,
    input wire logic wait_mode,
    output logic xfer_req,
    output touch_scan_pkg::xfer_t xfer,
    input wire logic xfer_ack,
    output logic scan_done,
    input wire logic scan_done_ack
);
    import touch_scan_pkg::*;

    // Channel index is five bits wide
    if (NUM_CH < 1 || NUM_CH > 32)
    begin : g_bad_num_ch
        $error("NUM_CH must lie in 1..32");
    end

    typedef struct packed {
        seq_state_t st;
        logic [6:0] tmr;
        logic [15:0] prim, res1, res2;
        logic [4:0] sec, ch, chsel, preset;
        logic [1:0] trig;
        logic [27:0] times;
        logic [11:0] dest, xaddr;
        logic [31:0] rdata;
        logic coarse_done, short_on, ovf, wexit, in_wait, start;
        logic short_en, skip1, skip5, scan, order, cmp_prev, ext_prev;
        pins_t pins;
    } core_t;
    core_t q_q, q_d;
    logic [2:0] syn;
    logic sense_hi, trig_hit, wr_acc, step, last_ch;
    logic [4:0] top_ch;
    seq_state_t nxt;

    // Pins and triggers come from outside the clock domain
    sync2 #(.W(3)) u_sync (.clk(clk), .srst(srst), .q(syn),
        .d({sense_pin_i, compare_match_flag, external_trigger_pin}));
    assign sense_hi = syn[2];

    // Known register offsets
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return a inside {OFF_CTRL, OFF_CHAN, OFF_TIME, OFF_PRESET, OFF_DEST,
                         OFF_STATUS, OFF_COUNT, OFF_RESULT};
    endfunction

    // Length field minus one of each timed state; zero means one cycle
    function automatic logic [6:0] period_len(input core_t c);
        case (c.st)
            S_CHARGE: return c.times[TIME_CHG +: 7];
            S_C_DIS1, S_F_DIS1: return {3'h0, c.times[TIME_DIS1 +: 4]};
            S_C_DIS2, S_F_DIS2: return {5'h00, c.times[TIME_DIS2 +: 2]};
            S_C_FLOAT, S_F_FLOAT: return {4'h0, c.times[TIME_FLT +: 3]};
            S_C_SETTLE, S_F_SETTLE: return {3'h0, c.times[TIME_SET +: 4]};
            S_C_POST, S_F_CHECK: return {3'h0, c.times[TIME_POST +: 4]};
            default: return 7'h00;
        endcase
    endfunction

    // Pin drive per state; every other state floats all three
    function automatic pins_t pin_decode(input seq_state_t s);
        pins_t p;
        p = '0;
        p.charge_o = (s == S_CHARGE);
        p.charge_oe = (s == S_CHARGE);
        p.sense_oe = s inside {S_C_DIS1, S_F_DIS1, S_C_DIS2, S_F_DIS2};
        p.bleed_oe = s inside {S_C_DIS2, S_F_DIS2};
        return p;
    endfunction

    assign top_ch = (5'(NUM_CH - 1) < q_q.chsel) ? 5'(NUM_CH - 1) : q_q.chsel;
    assign last_ch = !q_q.scan || (q_q.order ? (q_q.ch == 5'h00) : (q_q.ch == top_ch));
    assign wr_acc = psel && penable && pwrite;

    // Start condition per trigger select
    always_comb
    begin
        unique case (q_q.trig)
            TRIG_SW: trig_hit = 1'b1;
            TRIG_CMP: trig_hit = syn[1] && !q_q.cmp_prev;
            TRIG_EXT: trig_hit = !syn[0] && q_q.ext_prev;
            default: trig_hit = 1'b0;
        endcase
    end

    // Registers, sequencer and counters; flag sets follow clears so a set wins
    always_comb
    begin
        q_d = q_q;
        q_d.cmp_prev = syn[1];
        q_d.ext_prev = syn[0];
        step = (q_q.tmr == period_len(q_q));
        nxt = seq_state_t'(5'(q_q.st) + 5'h01);
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                OFF_CTRL: q_d.rdata = {22'h0, q_q.trig, 3'h0, q_q.skip5, q_q.skip1, q_q.short_en, 1'b0, q_q.start};
                OFF_CHAN: q_d.rdata = {22'h0, q_q.order, q_q.scan, 3'h0, q_q.chsel};
                OFF_TIME: q_d.rdata = {4'h0, q_q.times};
                OFF_PRESET: q_d.rdata = {27'h0, q_q.preset};
                OFF_DEST: q_d.rdata = {20'h0, q_q.dest};
                OFF_STATUS: q_d.rdata = {22'h0, q_q.wexit, q_q.ovf, 3'h0, 5'(q_q.st)};
                OFF_COUNT: q_d.rdata = {11'h0, q_q.sec, q_q.prim};
                OFF_RESULT: q_d.rdata = {q_q.res2, q_q.res1};
                default: q_d.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_acc)
        begin
            unique case (paddr)
                OFF_CTRL:
                begin
                    q_d.start = pwdata[CTRL_START];
                    q_d.short_en = pwdata[CTRL_SHORT];
                    q_d.skip1 = pwdata[CTRL_SKIP1];
                    q_d.skip5 = pwdata[CTRL_SKIP5];
                    q_d.trig = pwdata[CTRL_TRIG +: 2];
                end
                OFF_CHAN:
                begin
                    q_d.chsel = pwdata[CHAN_SEL +: 5];
                    q_d.scan = pwdata[CHAN_SCAN];
                    q_d.order = pwdata[CHAN_ORDER];
                end
                OFF_TIME: q_d.times = pwdata[27:0];
                OFF_PRESET: q_d.preset = pwdata[4:0];
                OFF_DEST: q_d.dest = pwdata[11:0];
                OFF_STATUS:
                begin
                    q_d.ovf = q_q.ovf && !pwdata[STAT_OVF];
                    q_d.wexit = q_q.wexit && !pwdata[STAT_WEXIT];
                end
                default: ;
            endcase
        end
        // A stopped sequencer freezes state and counters
        if (q_q.st != S_IDLE && !q_q.start)
            step = 1'b0;
        else
        begin
            unique case (q_q.st)
                S_IDLE:
                begin
                    step = q_q.start && trig_hit;
                    q_d.in_wait = wait_mode;
                    q_d.xaddr = q_q.dest;
                    q_d.ch = (q_q.scan && !q_q.order) ? 5'h00 : top_ch;
                end
                S_LOAD:
                begin
                    q_d.prim = 16'h0000;
                    q_d.sec = q_q.preset;
                    q_d.coarse_done = 1'b0;
                end
                S_INIT:
                begin
                    q_d.sec = q_q.preset;
                    nxt = q_q.skip1 ? S_C_DIS2 : S_C_DIS1;
                end
                S_C_FLOAT, S_F_FLOAT:
                    if (q_q.short_en)
                        q_d.short_on = 1'b1;
                S_C_DUMMY, S_F_DUMMY2:
                    if (q_q.skip5)
                        nxt = seq_state_t'(5'(q_q.st) + 5'h02);
                S_C_JUDGE:
                begin
                    if (!sense_hi)
                    begin
                        q_d.res1 = q_q.prim;
                        q_d.coarse_done = 1'b1;
                    end
                    else if (q_q.prim == PRIMARY_LIMIT)
                    begin
                        q_d.ovf = 1'b1;
                        nxt = S_XFER_REQ;
                    end
                    else
                        q_d.prim = q_q.prim + 16'h0001;
                end
                S_C_POST:
                begin
                    if (q_q.short_en)
                        q_d.short_on = 1'b0;
                    if (q_q.coarse_done)
                        nxt = S_F_DUMMY;
                    else
                        nxt = q_q.skip1 ? S_C_DIS2 : S_C_DIS1;
                end
                S_F_DUMMY:
                    nxt = q_q.skip1 ? S_F_DIS2 : S_F_DIS1;
                S_F_JUDGE:
                begin
                    if (!sense_hi)
                    begin
                        if (q_q.sec < q_q.preset)
                            q_d.sec = q_q.sec + 5'h01;
                    end
                    else if (q_q.prim == PRIMARY_LIMIT)
                    begin
                        q_d.ovf = 1'b1;
                        nxt = S_XFER_REQ;
                    end
                    else
                    begin
                        q_d.prim = q_q.prim + 16'h0001;
                        if (q_q.sec != 5'h00)
                            q_d.sec = q_q.sec - 5'h01;
                    end
                end
                S_F_CHECK:
                begin
                    if (q_q.short_en)
                        q_d.short_on = 1'b0;
                    if (q_q.sec == 5'h00)
                        q_d.res2 = q_q.prim;
                    else
                        nxt = q_q.skip1 ? S_F_DIS2 : S_F_DIS1;
                end
                S_XFER_REQ:
                begin
                    step = xfer_ack;
                    q_d.xaddr = xfer_ack ? q_q.xaddr + REC_BYTES : q_q.xaddr;
                end
                S_NEXT_CH:
                begin
                    if (last_ch)
                        nxt = S_XFER_WAIT;
                    else
                    begin
                        nxt = S_LOAD;
                        q_d.ch = q_q.order ? q_q.ch - 5'h01 : q_q.ch + 5'h01;
                    end
                end
                S_DONE:
                begin
                    step = scan_done_ack;
                    nxt = S_IDLE;
                    q_d.start = q_q.start && !scan_done_ack;
                end
                default: ;
            endcase
        end
        // Period timer restarts on each step, holds while idle or stopped
        if (step)
            q_d.st = nxt;
        q_d.tmr = step ? 7'h00 : (q_q.st != S_IDLE && q_q.start) ? q_q.tmr + 7'h01 : q_q.tmr;
        // Initialize write returns the sequencer to zero
        if (wr_acc && paddr == OFF_CTRL && pwdata[CTRL_INIT])
        begin
            q_d.st = S_IDLE;
            q_d.tmr = 7'h00;
            q_d.short_on = 1'b0;
        end
        // Measurement data becomes undefined; software must discard it
        if (q_q.st != S_IDLE && q_q.in_wait && !wait_mode)
            q_d.wexit = 1'b1;
        q_d.pins = pin_decode(q_d.st);
    end

    // All state in one register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            q_q <= '0;
            q_q.st <= S_IDLE;
            q_q.preset <= PRESET_RST;
            q_q.sec <= PRESET_RST;
        end
        else
            q_q <= q_d;
    end

    // Zero-wait slave; read data latched in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);
    assign prdata = q_q.rdata;
    assign pins = q_q.pins;
    assign short_on = q_q.short_on;
    assign channel = q_q.ch;
    assign xfer_req = (q_q.st == S_XFER_REQ) && q_q.start;
    assign xfer = '{addr: q_q.xaddr, data: {q_q.res2, q_q.res1}, dma_sel: q_q.in_wait};
    assign scan_done = (q_q.st == S_DONE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    charge_drive_a: assert property ((q_q.st == S_CHARGE) |-> pins.charge_o && pins.charge_oe && !pins.sense_oe)
        else $error("charge pin not driven in charge state");
    charge_len_a: assert property ($fell(q_q.st == S_CHARGE) && !$past(srst) && q_q.st == S_INIT
        |-> $past(q_q.tmr) == $past(q_q.times[TIME_CHG +: 7]))
        else $error("charge period length wrong");
    coarse_fine_a: assert property (q_q.st == S_C_JUDGE && q_q.start && !sense_hi |=> q_q.coarse_done)
        else $error("low judgement did not end coarse phase");
    sec_down_a: assert property (q_q.st == S_F_JUDGE && q_q.start && sense_hi && q_q.prim != PRIMARY_LIMIT
        && q_q.sec != 5'h00 |=> q_q.sec == $past(q_q.sec) - 5'h01)
        else $error("secondary did not count down");
    prim_hold_a: assert property (q_q.st inside {S_C_JUDGE, S_F_JUDGE} && q_q.start && !sense_hi
        |=> $stable(q_q.prim))
        else $error("primary moved on low judgement");
    ovf_jump_a: assert property (q_q.st == S_C_JUDGE && q_q.start && sense_hi && q_q.prim == PRIMARY_LIMIT
        && !wr_acc |=> q_q.ovf && q_q.st == S_XFER_REQ)
        else $error("overflow did not jump to transfer");
    xfer_hold_a: assert property (xfer_req && !xfer_ack && !wr_acc |=> xfer_req && $stable(xfer))
        else $error("transfer request dropped before ack");
    stop_freeze_a: assert property (!q_q.start && q_q.st != S_IDLE && !wr_acc |=> $stable(q_q.st) && $stable(q_q.prim))
        else $error("stopped sequencer moved");
    done_idle_a: assert property (scan_done && scan_done_ack && q_q.start |=> q_q.st == S_IDLE && !q_q.start)
        else $error("completion acknowledge did not return to idle");
endmodule // touch_scan_ctrl
`default_nettype wire

// ===== sim/electrode_model.sv
/*
 Electrode and reference network: one comparator level per dual discharge.
 Assumes the pin drive carrier of the package and the controller's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module electrode_model
(
    input wire logic clk,
    input wire touch_scan_pkg::pins_t pins,
    input wire logic [15:0] drop,
    output logic sense
);
    import touch_scan_pkg::*;
    logic [15:0] k_q = 16'h0000;
    logic bleed_q = 1'b0;
    // Charging restores the full level; each dual discharge removes one step
    always_ff @(posedge clk)
    begin
        bleed_q <= pins.bleed_oe;
        if (pins.charge_oe && pins.charge_o)
            k_q <= 16'h0000;
        else if (pins.bleed_oe && !bleed_q)
            k_q <= k_q + 16'h0001;
    end
    // High until drop steps, then a high-high-low ripple so the fine phase ends
    assign sense = (k_q < drop) || ((k_q - drop) % 3 != 0);
endmodule // electrode_model
`default_nettype wire

// ===== sim/capacitive_touch_scan_controller_bench.sv
/*
 Self-checking bench of the touch scan controller with an electrode model.
 Assumes the package offsets and a zero-wait APB slave.
*/
`timescale 1ns/1ps
`default_nettype none
module capacitive_touch_scan_controller_bench;
    import touch_scan_pkg::*;
    localparam int CHG = 3;
    localparam int DIS1 = 2;
    localparam int DIS2 = 1;
    localparam int FLT = 1;
    localparam int SET = 2;
    localparam logic [31:0] TIMEW = 32'h0021_1203;
    localparam logic [31:0] DEST = 32'h0000_0100;
    localparam int PRE = 3;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cmp = 1'b0, ext = 1'b1, wm = 1'b0, ack = 1'b0, dack = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
    logic pready, pslverr, sense, short_on, xfer_req, scan_done, err, sk1, shx;
    logic [4:0] channel;
    logic [15:0] drop = 16'h0005;
    pins_t pins;
    xfer_t xfer;
    int errors = 0, n_compared = 0, chg_n = 0, sl_n = 0, bl_n = 0, sh_n = 0;
    // 20 MHz clock
    always #25 clk = ~clk;
    touch_scan_ctrl #(.NUM_CH(18)) i_touch_scan_ctrl (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sense_pin_i(sense), .pins(pins), .short_on(short_on), .channel(channel), .compare_match_flag(cmp),
        .external_trigger_pin(ext), .wait_mode(wm), .xfer_req(xfer_req), .xfer(xfer), .xfer_ack(ack),
        .scan_done(scan_done), .scan_done_ack(dack));
    electrode_model i_electrode_model (.clk(clk), .pins(pins), .drop(drop), .sense(sense));
    // Pin drive tallies, judged against the programmed period lengths
    always @(posedge clk)
    begin
        chg_n += int'(pins.charge_oe === 1'b1 && pins.charge_o === 1'b1);
        sl_n += int'(pins.sense_oe === 1'b1 && pins.sense_o === 1'b0);
        bl_n += int'(pins.bleed_oe === 1'b1 && pins.bleed_o === 1'b0);
        sh_n += int'(short_on === 1'b1);
    end
    task automatic tally_and_finish;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            r = prdata;
            e = pslverr;
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask
    // Reference record: coarse highs until drop, then up/down secondary down to zero
    function automatic logic [31:0] rec(input int d, input int p, output int j);
        int pc, sc;
        pc = d - 1;
        sc = p;
        j = d;
        while (sc != 0)
        begin
            j++;
            if ((j - d) % 3 != 0)
            begin
                pc++;
                sc--;
            end
            else if (sc < p)
                sc++;
        end
        return {16'(pc), 16'(d - 1)};
    endfunction
    task automatic go(input logic [31:0] ctrl);
        chg_n = 0;
        sh_n = 0;
        sl_n = 0;
        bl_n = 0;
        wr(OFF_CTRL, ctrl);
    endtask
    task automatic take;
        do @(posedge clk); while (xfer_req !== 1'b1);
    endtask
    task automatic pulse_ack;
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
    endtask
    task automatic close_run;
        do @(posedge clk); while (scan_done !== 1'b1);
        dack <= 1'b1;
        @(posedge clk);
        dack <= 1'b0;
        rd(OFF_STATUS, rdv);
        chk(rdv[4:0], 0);
    endtask
    task automatic run(input int n, input int ch0, input bit desc, input logic wmx);
        logic [31:0] exp;
        int j;
        exp = rec(drop, PRE, j);
        for (int k = 0; k < n; k++)
        begin
            take();
            chk(32'(channel), desc ? ch0 - k : ch0 + k);
            chk(32'(xfer.addr), DEST + 4 * k);
            chk(xfer.data, exp);
            chk(32'(xfer.dma_sel), 32'(wmx));
            pulse_ack();
        end
        close_run();
        chk(chg_n, n * (CHG + 1));
        chk(bl_n, n * j * (DIS2 + 1));
        chk(sl_n, n * j * (DIS2 + 1 + (sk1 ? 0 : DIS1 + 1)));
        chk(sh_n, shx ? n * j * (FLT + SET + 5) : 0);
    endtask
    task automatic single_sw;
        wr(OFF_CHAN, 32'h0000_0005);
        shx = 1'b1;
        go(32'h0000_0005);
        run(1, 5, 0, 1'b0);
        shx = 1'b0;
    endtask
    // Descending scan in wait mode, first discharge and settle skipped
    task automatic scan_desc_wait;
        sk1 = 1'b1;
        wr(OFF_CHAN, 32'h0000_0302);
        wm <= 1'b1;
        go(32'h0000_0019);
        run(3, 2, 1, 1'b1);
        wm <= 1'b0;
        sk1 = 1'b0;
    endtask
    task automatic cmp_trig;
        wr(OFF_CHAN, 32'h0000_0101);
        go(32'h0000_0201);
        repeat (8) @(posedge clk);
        rd(OFF_STATUS, rdv);
        chk(rdv[4:0], 0);
        cmp <= 1'b1;
        run(2, 0, 0, 1'b0);
        cmp <= 1'b0;
    endtask
    task automatic ext_trig;
        wr(OFF_CHAN, 32'h0000_0011);
        go(32'h0000_0301);
        repeat (8) @(posedge clk);
        rd(OFF_STATUS, rdv);
        chk(rdv[4:0], 0);
        ext <= 1'b0;
        run(1, 17, 0, 1'b0);
        ext <= 1'b1;
    endtask
    // Software stop freezes state and counters; initialize clears the state only
    task automatic sw_stop;
        logic [31:0] s, c;
        wr(OFF_CHAN, 32'h0000_0000);
        wm <= 1'b1;
        go(32'h0000_0001);
        repeat (30) @(posedge clk);
        wm <= 1'b0;
        wr(OFF_CTRL, 32'h0000_0000);
        rd(OFF_STATUS, s);
        rd(OFF_COUNT, c);
        chk(s[9], 1);
        repeat (20) @(posedge clk);
        rd(OFF_STATUS, rdv);
        chk(rdv, s);
        rd(OFF_COUNT, rdv);
        chk(rdv, c);
        wr(OFF_CTRL, 32'h0000_0002);
        rd(OFF_STATUS, rdv);
        chk(rdv[4:0], 0);
        rd(OFF_COUNT, rdv);
        chk(rdv, c);
    endtask
    task automatic overflow;
        drop = 16'hffff;
        go(32'h0000_0001);
        take();
        rd(OFF_STATUS, rdv);
        chk(rdv[8], 1);
        rd(OFF_COUNT, rdv);
        chk(rdv[15:0], PRIMARY_LIMIT);
        pulse_ack();
        close_run();
    endtask
    // Hang guard, well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial
    begin
        sk1 = 1'b0;
        shx = 1'b0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rd(OFF_PRESET, rdv);
        chk(rdv, 32'(PRESET_RST));
        rd(OFF_COUNT, rdv);
        chk(rdv, 32'h0007_0000);
        apb(1'b0, 8'h20, 32'h0000_0000, rdv, err);
        chk({rdv[30:0], err}, 32'h0000_0001);
        wr(OFF_TIME, TIMEW);
        wr(OFF_PRESET, PRE);
        wr(OFF_DEST, DEST);
        single_sw();
        scan_desc_wait();
        cmp_trig();
        ext_trig();
        sw_stop();
        overflow();
        tally_and_finish();
    end
endmodule // capacitive_touch_scan_controller_bench
`default_nettype wire
